// ===== verilog/dcp_map.svh
// register map constants and fixed figures of the control port
`ifndef DCP_MAP_SVH
`define DCP_MAP_SVH
`define DCP_NUM_REGS 21
`define DCP_REG_LAST 5'h14
`define DCP_ADDR_W 5
`define DCP_DATA_W 8
`define DCP_SLV_ADDR_HI 5'h04
`define DCP_RST_CTRL1 8'h0D
`define DCP_RST_CTRL2 8'h22
`define DCP_RST_CTRL3 8'h00
`define DCP_RST_OTHER 8'h00
`define DCP_IDX_CTRL1 5'h00
`define DCP_IDX_CTRL2 5'h01
`define DCP_IDX_CTRL3 5'h02
`define DCP_TIMING_RST_BIT 0
`define DCP_TW_BITS 5'h10
`define DCP_TW_CHIP_HI 15
`define DCP_TW_CHIP_LO 14
`define DCP_TW_RW_BIT 13
`define DCP_TW_ADDR_HI 12
`define DCP_TW_ADDR_LO 8
`define DCP_I2C_BYTE_BITS 4'h8
`define DCP_I2C_ACK_BITS 4'h9
`define DCP_SYNC_W 10
`endif

// ===== verilog/dcp_pkg.sv
// types shared by the control port modules
package dcp_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_SUB   = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100
  } dcp_i2c_state_t;

  typedef struct packed {
    logic en;
    logic [4:0] addr;
    logic [7:0] data;
  } dcp_wr_t;
endpackage : dcp_pkg

// ===== verilog/dcp_sync.sv
// two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
`default_nettype none
module dcp_sync #(
  parameter int WIDTH = 10
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= d_in;
      sync_r <= meta_r;
    end
  end

  assign q_out = sync_r;
endmodule : dcp_sync
`default_nettype wire

// ===== verilog/dcp_regfile.sv
// twenty-one byte control registers with power-down initialisation
`timescale 1ns/1ps
`default_nettype none
`include "dcp_map.svh"
module dcp_regfile #(
  parameter int NUM_REGS = `DCP_NUM_REGS
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic clear_in,
  input wire dcp_pkg::dcp_wr_t wr_in,
  input wire logic [4:0] rd_addr_in,
  output logic [7:0] rd_data_out,
  output logic [NUM_REGS*8-1:0] image_out
);
  import dcp_pkg::*;

  logic [7:0] regs_r [NUM_REGS];

  function automatic logic [7:0] reset_value(input int idx);
    logic [4:0] a;
    a = 5'(idx);
    case (a)
      `DCP_IDX_CTRL1: reset_value = `DCP_RST_CTRL1;
      `DCP_IDX_CTRL2: reset_value = `DCP_RST_CTRL2;
      `DCP_IDX_CTRL3: reset_value = `DCP_RST_CTRL3;
      default: reset_value = `DCP_RST_OTHER;
    endcase
  endfunction : reset_value

  // power-down pin low restores every default
  always_ff @(posedge clk_in) begin // RL5 RL16
    for (int i = 0; i < NUM_REGS; i++) begin
      if (rst_in || clear_in) begin
        regs_r[i] <= reset_value(i);
      end else if (wr_in.en && wr_in.addr == 5'(i)) begin
        regs_r[i] <= wr_in.data;
      end
    end
  end

  // unmapped addresses read as zero
  assign rd_data_out = (rd_addr_in < 5'(NUM_REGS)) ? regs_r[rd_addr_in] : 8'h00;

  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++) begin : g_img
      assign image_out[g*8 +: 8] = regs_r[g];
    end
  endgenerate
endmodule : dcp_regfile
`default_nettype wire

// ===== verilog/dcp_top.sv
// control port: three-wire write port and two-wire slave over a shared register file
//
// Summary of operation
// RL1: three-wire frame: chip, write flag, address, data
// RL2: three-wire write commits on select rising edge
// RL3: three-wire bits sampled on serial clock rise
// RL4: host keeps three-wire clock at 5MHz max; the bench host model runs it at 15.625MHz (64ns period)
// RL5: power-down resets registers; timing bit does not
// RL6: slave address 00100 plus two strap pins
// RL7: ack matching address, then every written byte
// RL8: second byte is register address, MSB first
// RL9: write stores, increments, wraps 14H to 00H
// RL10: last attenuation register only via multi-byte; the code also accepts single-byte writes to it on both ports
// RL11: read: ack, send counter byte, increment
// RL12: one address counter shared by both directions
// RL13: consecutive reads wrap 14H to 00H
// RL14: nack then stop ends sending, releases data
// RL15: random read: address write, repeated start, read
// RL16: twenty-one byte registers, 00H through 14H
// RL17: works at 100kHz and 400kHz bus clocks
// RL18: both bus lines open-drain, pull low only
// RL19: start and stop detected with clock high
// RL20: data changes only while clock low
// RL21: eight bits MSB first, then ack bit
// RL22: direction fixed until repeated start or stop
// RL23: port chosen by bus-select and parallel-select pins
// RL24: writes ignored while power-down pin low
// RL25: writes to 15H through 1FH discarded
// RL26: three-wire chip address mismatch ignored
// RL27: three-wire frame not sixteen bits discarded
`timescale 1ns/1ps
`default_nettype none
`include "dcp_map.svh"
module dcp_top (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic cmd_serial_clock_in,
  input wire logic cmd_select_n_in,
  input wire logic cmd_serial_in_in,
  input wire logic chip_addr_strap_hi_in,
  input wire logic chip_addr_strap_lo_in,
  input wire logic power_down_pin_n_in,
  input wire logic bus_select_pin_in,
  input wire logic parallel_select_pin_in,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic timing_reset_bit_out,
  output logic [`DCP_NUM_REGS*8-1:0] reg_image_out,
  output dcp_pkg::dcp_wr_t last_write_out
);
  import dcp_pkg::*;

  // pin synchronisation
  logic [`DCP_SYNC_W-1:0] raw_w;
  logic [`DCP_SYNC_W-1:0] syn_w;
  assign raw_w = {cmd_serial_clock_in, cmd_select_n_in, cmd_serial_in_in, chip_addr_strap_hi_in,
                  chip_addr_strap_lo_in, power_down_pin_n_in, bus_select_pin_in,
                  parallel_select_pin_in, scl_in, sda_in};

  dcp_sync #(.WIDTH(`DCP_SYNC_W)) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .d_in(raw_w),
    .q_out(syn_w)
  );

  wire cmd_serial_clock_s = syn_w[9];
  wire csn_s = syn_w[8];
  wire cdi_s = syn_w[7];
  wire [1:0] strap_w = syn_w[6:5];
  wire pdn_n_s = syn_w[4];
  wire bus_s = syn_w[3];
  wire ps_s = syn_w[2];
  wire scl_s = syn_w[1];
  wire sda_s = syn_w[0];

  logic cmd_serial_clock_prev_r;
  logic csn_prev_r;
  logic scl_prev_r;
  logic sda_prev_r;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cmd_serial_clock_prev_r <= 1'b0;
      csn_prev_r <= 1'b0;
      scl_prev_r <= 1'b0;
      sda_prev_r <= 1'b0;
    end else begin
      cmd_serial_clock_prev_r <= cmd_serial_clock_s;
      csn_prev_r <= csn_s;
      scl_prev_r <= scl_s;
      sda_prev_r <= sda_s;
    end
  end

  // port selection
  wire tw_mode_w = !bus_s && !ps_s; // RL23
  wire i2c_mode_w = bus_s && !ps_s; // RL23

  // three-wire command shifter
  logic [15:0] tw_shift_r;
  logic [4:0] tw_cnt_r;

  wire tw_clk_rise_w = cmd_serial_clock_s && !cmd_serial_clock_prev_r;
  wire tw_sel_rise_w = csn_s && !csn_prev_r;
  wire tw_sel_fall_w = !csn_s && csn_prev_r;
  wire tw_match_w = tw_shift_r[`DCP_TW_CHIP_HI:`DCP_TW_CHIP_LO] == strap_w; // RL26
  wire tw_full_w = tw_cnt_r == `DCP_TW_BITS; // RL27
  wire tw_wr_w = tw_mode_w && tw_sel_rise_w && tw_full_w && tw_match_w && tw_shift_r[`DCP_TW_RW_BIT]; // RL2 RL1

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tw_shift_r <= 16'h0000;
      tw_cnt_r <= 5'h00;
    end else if (tw_sel_fall_w) begin
      tw_cnt_r <= 5'h00;
    end else if (tw_clk_rise_w && !csn_s) begin // RL3
      tw_shift_r <= {tw_shift_r[14:0], cdi_s};
      if (tw_cnt_r != 5'h1F) begin
        tw_cnt_r <= tw_cnt_r + 5'h01;
      end
    end
  end

  // two-wire slave
  dcp_i2c_state_t state_r;
  logic [7:0] shift_r;
  logic [3:0] bit_cnt_r;
  logic ack_phase_r;
  logic sda_drive_r;
  logic rw_r;
  logic mack_r;
  logic [4:0] ptr_r;
  logic [7:0] rd_data_w;

  wire scl_rise_w = scl_s && !scl_prev_r;
  wire scl_fall_w = !scl_s && scl_prev_r;
  wire start_w = scl_s && scl_prev_r && sda_prev_r && !sda_s; // RL19
  wire stop_w = scl_s && scl_prev_r && !sda_prev_r && sda_s; // RL19
  wire [6:0] my_addr_w = {`DCP_SLV_ADDR_HI, strap_w}; // RL6
  wire addr_match_w = shift_r[7:1] == my_addr_w;
  wire byte_done_w = scl_fall_w && !ack_phase_r && bit_cnt_r == `DCP_I2C_BYTE_BITS; // RL21
  wire ack_done_w = scl_fall_w && ack_phase_r && bit_cnt_r == `DCP_I2C_ACK_BITS;
  wire i2c_wr_w = i2c_mode_w && byte_done_w && state_r == ST_WDATA;
  wire rd_load_w = ack_done_w && ((state_r == ST_ADDR && rw_r) || (state_r == ST_RDATA && mack_r)); // RL11 RL13
  wire [4:0] ptr_next_w = (ptr_r >= `DCP_REG_LAST) ? 5'h00 : ptr_r + 5'h01; // RL9 RL13

  // shared address counter
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ptr_r <= 5'h00;
    end else if (byte_done_w && state_r == ST_SUB) begin // RL8
      ptr_r <= shift_r[4:0];
    end else if (i2c_wr_w || rd_load_w) begin // RL12
      ptr_r <= ptr_next_w;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in || !i2c_mode_w) begin
      state_r <= ST_IDLE;
      shift_r <= 8'h00;
      bit_cnt_r <= 4'h0;
      ack_phase_r <= 1'b0;
      sda_drive_r <= 1'b0;
      rw_r <= 1'b0;
      mack_r <= 1'b0;
    end else if (start_w) begin // RL22
      state_r <= ST_ADDR;
      bit_cnt_r <= 4'h0;
      ack_phase_r <= 1'b0;
      sda_drive_r <= 1'b0;
    end else if (stop_w) begin // RL14
      state_r <= ST_IDLE;
      sda_drive_r <= 1'b0;
    end else if (scl_rise_w && state_r != ST_IDLE) begin // RL20
      bit_cnt_r <= bit_cnt_r + 4'h1;
      if (state_r != ST_RDATA && !ack_phase_r) begin
        shift_r <= {shift_r[6:0], sda_s};
      end
      if (state_r == ST_RDATA && ack_phase_r) begin
        mack_r <= !sda_s;
      end
    end else if (byte_done_w) begin
      ack_phase_r <= 1'b1;
      case (state_r)
        ST_ADDR: begin
          if (addr_match_w) begin // RL7
            sda_drive_r <= 1'b1;
            rw_r <= shift_r[0];
          end else begin
            state_r <= ST_IDLE;
          end
        end
        ST_SUB, ST_WDATA: sda_drive_r <= 1'b1; // RL7 RL21
        ST_RDATA: sda_drive_r <= 1'b0;
        default: state_r <= ST_IDLE;
      endcase
    end else if (ack_done_w) begin
      ack_phase_r <= 1'b0;
      bit_cnt_r <= 4'h0;
      case (state_r)
        ST_ADDR: begin
          if (rw_r) begin // RL11
            state_r <= ST_RDATA;
            shift_r <= rd_data_w;
            sda_drive_r <= !rd_data_w[7];
          end else begin
            state_r <= ST_SUB;
            sda_drive_r <= 1'b0;
          end
        end
        ST_SUB: begin
          state_r <= ST_WDATA;
          sda_drive_r <= 1'b0;
        end
        ST_WDATA: sda_drive_r <= 1'b0;
        ST_RDATA: begin
          if (mack_r) begin // RL13
            shift_r <= rd_data_w;
            sda_drive_r <= !rd_data_w[7];
          end else begin // RL14
            state_r <= ST_IDLE;
            sda_drive_r <= 1'b0;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end else if (scl_fall_w && state_r == ST_RDATA && !ack_phase_r && bit_cnt_r != 4'h0) begin // RL20
      shift_r <= {shift_r[6:0], 1'b0};
      sda_drive_r <= !shift_r[6];
    end
  end

  // open-drain lines: pull low or release; no stretching needed at this clock rate
  assign sda_out = 1'b0; // RL18
  assign sda_oe_out = sda_drive_r; // RL18
  assign scl_out = 1'b0; // RL17
  assign scl_oe_out = 1'b0; // RL17

  // register write merge
  dcp_wr_t wr_w;
  assign wr_w.en = pdn_n_s && (tw_wr_w || i2c_wr_w) && wr_w.addr <= `DCP_REG_LAST; // RL24 RL25
  assign wr_w.addr = tw_wr_w ? tw_shift_r[`DCP_TW_ADDR_HI:`DCP_TW_ADDR_LO] : ptr_r;
  assign wr_w.data = tw_wr_w ? tw_shift_r[7:0] : shift_r;

  dcp_regfile #(.NUM_REGS(`DCP_NUM_REGS)) u_regs (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .clear_in(!pdn_n_s),
    .wr_in(wr_w),
    .rd_addr_in(ptr_r),
    .rd_data_out(rd_data_w),
    .image_out(reg_image_out)
  );

  // timing reset follows its bit only, registers untouched
  assign timing_reset_bit_out = reg_image_out[`DCP_TIMING_RST_BIT]; // RL5

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      last_write_out <= '0;
    end else begin
      last_write_out <= wr_w;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence seq_addr_byte;
    byte_done_w && state_r == ST_ADDR;
  endsequence

  sequence seq_read_load;
    rd_load_w ##1 (state_r == ST_RDATA);
  endsequence

  tw_commit_edge_a: assert property (tw_wr_w |-> tw_sel_rise_w && tw_mode_w) // RL2
    else $error("three-wire write without select rise");
  tw_frame_len_a: assert property (tw_wr_w |-> tw_cnt_r == 5'h10 && tw_match_w) // RL27
    else $error("three-wire write with bad length or chip address");
  tw_bit_count_a: assert property (tw_clk_rise_w && !csn_s && !tw_sel_fall_w && tw_cnt_r < 5'h10
    |=> tw_cnt_r == $past(tw_cnt_r) + 5'h01) // RL3
    else $error("three-wire bit not counted");
  wr_gated_a: assert property (wr_w.en |-> pdn_n_s && wr_w.addr <= 5'h14) // RL24
    else $error("write while powered down or out of range");
  addr_ack_a: assert property (seq_addr_byte and (addr_match_w && !start_w)
    |=> sda_drive_r && ack_phase_r ##1 sda_drive_r) // RL7
    else $error("matching address not acknowledged");
  addr_nack_a: assert property (seq_addr_byte and !addr_match_w |=> !sda_drive_r && state_r == ST_IDLE) // RL7
    else $error("foreign address acknowledged");
  ptr_wrap_a: assert property ((i2c_wr_w || rd_load_w) && ptr_r == 5'h14 |=> ptr_r == 5'h00) // RL9
    else $error("address counter did not wrap");
  read_incr_a: assert property (seq_read_load |-> ptr_r == (($past(ptr_r, 1) == 5'h14) ? 5'h00
    : $past(ptr_r, 1) + 5'h01) && shift_r == $past(rd_data_w, 1)) // RL11
    else $error("read byte not loaded or counter not advanced");
  stop_release_a: assert property (stop_w && i2c_mode_w |=> !sda_oe_out && state_r == ST_IDLE [*2]) // RL14
    else $error("data line held after stop");
  mode_sel_a: assert property (i2c_wr_w || tw_wr_w |-> !ps_s) // RL23
    else $error("write in parallel mode");
endmodule : dcp_top
`default_nettype wire

// ===== verif/dcp_host.sv
// host model: three-wire command writer and two-wire bus master
`timescale 1ns/1ps
`default_nettype none
module dcp_host (
  input wire logic scl_in,
  input wire logic sda_in,
  output logic cmd_serial_clock_out,
  output logic cmd_select_n_out,
  output logic cmd_serial_in_out,
  output logic scl_pull_out,
  output logic sda_pull_out,
  output logic [7:0] got_out,
  output logic got_v_out
);
  initial begin
    cmd_serial_clock_out = 1'b1;
    cmd_select_n_out = 1'b1;
    cmd_serial_in_out = 1'b0;
    scl_pull_out = 1'b0;
    sda_pull_out = 1'b0;
    got_out = 8'h00;
    got_v_out = 1'b0;
  end
  // n bits from the top of f; serial clock stands high outside frames
  task automatic tw_send(input logic [15:0] f, input int n);
    cmd_select_n_out = 1'b0;
    #32;
    for (int i = 15; i > 15 - n; i--) begin
      cmd_serial_clock_out = 1'b0;
      cmd_serial_in_out = f[i];
      #32;
      cmd_serial_clock_out = 1'b1;
      #32;
    end
    cmd_select_n_out = 1'b1;
    cmd_serial_in_out = ~cmd_serial_in_out;
    #32;
  endtask : tw_send
  // entered and left with the clock pulled low
  task automatic bit_x(input logic b, output logic v);
    sda_pull_out = ~b;
    #32;
    scl_pull_out = 1'b0;
    wait (scl_in === 1'b1);
    v = sda_in;
    #32;
    scl_pull_out = 1'b1;
  endtask : bit_x
  task automatic byte_x(input logic [7:0] b, input logic ab, output logic [7:0] v, output logic av);
    for (int i = 7; i >= 0; i--) bit_x(b[i], v[i]);
    bit_x(ab, av);
  endtask : byte_x
  task automatic start();
    sda_pull_out = 1'b0;
    #32;
    scl_pull_out = 1'b0;
    #32;
    sda_pull_out = 1'b1;
    #32;
    scl_pull_out = 1'b1;
  endtask : start
  task automatic stop();
    sda_pull_out = 1'b1;
    #32;
    scl_pull_out = 1'b0;
    #32;
    sda_pull_out = 1'b0;
    #32;
  endtask : stop
  task automatic rd(input logic ab);
    logic [7:0] v;
    logic a;
    byte_x(8'hFF, ab, v, a);
    got_out = v;
    got_v_out = 1'b1;
    #5;
    got_v_out = 1'b0;
  endtask : rd
endmodule : dcp_host
`default_nettype wire

// ===== verif/dac_control_port_tb_top.sv
// self-checking bench for the control port with a host model
`timescale 1ns/1ps
`default_nettype none
`include "dcp_map.svh"
module dac_control_port_tb_top;
  import dcp_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic pdn_n = 1'b1;
  logic bsel = 1'b0;
  logic psel = 1'b0;
  logic s_hi, s_lo, ack;
  logic [7:0] d, r;
  logic [7:0] mdl [32];
  wire logic scl_w, sda_w, scl_o, scl_oe, sda_o, sda_oe, tr_bit, sck, ssn, sdi, scl_p, sda_p, got_v;
  wire logic [7:0] got;
  wire logic [`DCP_NUM_REGS*8-1:0] img;
  dcp_wr_t lw, e;
  int err_count = 0;
  int tests_run = 0;
  int a;
  dcp_wr_t wq [$];
  logic [7:0] rq [$];
  assign scl_w = ~(scl_oe | scl_p);
  assign sda_w = ~(sda_oe | sda_p);
  initial begin
    forever #2.5 clk_in = ~clk_in;
  end
  dcp_top i_dut (.clk_in(clk_in), .rst_in(rst_in), .cmd_serial_clock_in(sck), .cmd_select_n_in(ssn),
    .cmd_serial_in_in(sdi), .chip_addr_strap_hi_in(s_hi), .chip_addr_strap_lo_in(s_lo),
    .power_down_pin_n_in(pdn_n), .bus_select_pin_in(bsel), .parallel_select_pin_in(psel), .scl_in(scl_w),
    .scl_out(scl_o), .scl_oe_out(scl_oe), .sda_in(sda_w), .sda_out(sda_o), .sda_oe_out(sda_oe),
    .timing_reset_bit_out(tr_bit), .reg_image_out(img), .last_write_out(lw));
  dcp_host i_host (.scl_in(scl_w), .sda_in(sda_w), .cmd_serial_clock_out(sck), .cmd_select_n_out(ssn),
    .cmd_serial_in_out(sdi), .scl_pull_out(scl_p), .sda_pull_out(sda_p), .got_out(got), .got_v_out(got_v));
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] y);
    tests_run++;
    if (y !== x) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, x, y);
    end
  endtask : chk
  task automatic defs();
    for (int i = 0; i < 32; i++) mdl[i] = `DCP_RST_OTHER;
    mdl[0] = `DCP_RST_CTRL1;
    mdl[1] = `DCP_RST_CTRL2;
    mdl[2] = `DCP_RST_CTRL3;
  endtask : defs
  task automatic ew(input logic [4:0] ad, input logic [7:0] dt);
    wq.push_back(dcp_wr_t'{1'b1, ad, dt});
    mdl[ad] = dt;
  endtask : ew
  // lets pending results land, then compares the whole register image
  task automatic drain(input string nm);
    repeat (20) @(posedge clk_in);
    #1.5;
    chk("pending", 8'h00, 8'(wq.size() + rq.size()));
    chk("bus pins", 8'h00, {5'h00, scl_o, sda_o, scl_oe});
    for (int i = 0; i < `DCP_NUM_REGS; i++) chk("register", mdl[i], img[i*8 +: 8]);
    $display("test %s done", nm);
  endtask : drain
  task automatic ib(input logic [7:0] b, input logic xa);
    i_host.byte_x(b, 1'b1, r, ack);
    chk("ack", {7'h00, xa}, {7'h00, ack});
  endtask : ib
  task automatic slv(input logic [1:0] xo, input logic rw, input logic xa);
    i_host.start();
    ib({`DCP_SLV_ADDR_HI, s_hi ^ xo[1], s_lo ^ xo[0], rw}, xa);
  endtask : slv
  task automatic rb(input logic [4:0] ad, input logic hack);
    rq.push_back(mdl[ad]);
    i_host.rd(hack);
  endtask : rb
  always @(posedge clk_in) begin
    if (lw.en === 1'b1) begin
      e = wq.pop_front();
      chk("write address", {3'h0, e.addr}, {3'h0, lw.addr});
      chk("write data", e.data, lw.data);
    end
    if (got_v === 1'b1) chk("read data", rq.pop_front(), got);
  end
  initial begin
    #200000;
    err_count++;
    final_report();
  end
  initial begin
    void'($urandom(36));
    {s_hi, s_lo} = 2'($urandom);
    defs();
    repeat (3) @(posedge clk_in);
    #1.5 rst_in = 1'b0;
    drain("reset");
    chk("timing bit", 8'h01, {7'h00, tr_bit});
    for (int k = 0; k < 6; k++) begin
      a = $urandom_range(19, 0);
      d = 8'($urandom);
      ew(5'(a), d);
      i_host.tw_send({s_hi, s_lo, 1'b1, 5'(a), d}, 16);
    end
    drain("three-wire write");
    for (int k = 0; k < 4; k++) begin
      d = 8'($urandom);
      i_host.tw_send({k == 0 ? ~s_hi : s_hi, s_lo, k != 1, k == 2 ? 5'h15 : 5'h03, d}, k == 3 ? 15 : 16);
    end
    for (int k = 1; k < 4; k++) begin
      {bsel, psel} = 2'(k);
      i_host.tw_send({s_hi, s_lo, 1'b1, 5'h04, 8'h5A}, 16);
    end
    {bsel, psel} = 2'b00;
    drain("three-wire refusals");
    ew(5'h00, 8'h0C);
    i_host.tw_send({s_hi, s_lo, 1'b1, 5'h00, 8'h0C}, 16);
    drain("timing reset");
    chk("timing bit", 8'h00, {7'h00, tr_bit});
    bsel = 1'b1;
    drain("two-wire select");
    slv(2'b00, 1'b0, 1'b0);
    ib(8'h13, 1'b0);
    for (int k = 0; k < 3; k++) begin
      d = 8'($urandom);
      ew(5'((19 + k) % 21), d);
      ib(d, 1'b0);
    end
    i_host.stop();
    slv(2'b00, 1'b1, 1'b0);
    rb(5'h01, 1'b1);
    i_host.stop();
    slv(2'b10, 1'b0, 1'b1);
    i_host.stop();
    slv(2'b00, 1'b0, 1'b0);
    ib(8'h15, 1'b0);
    ib(8'hA5, 1'b0);
    i_host.stop();
    drain("two-wire write");
    slv(2'b00, 1'b0, 1'b0);
    ib(8'h13, 1'b0);
    slv(2'b00, 1'b1, 1'b0);
    for (int k = 0; k < 3; k++) rb(5'((19 + k) % 21), k == 2);
    i_host.stop();
    chk("sda release", 8'h00, {7'h00, sda_oe});
    drain("two-wire reads");
    bsel = 1'b0;
    pdn_n = 1'b0;
    defs();
    i_host.tw_send({s_hi, s_lo, 1'b1, 5'h05, 8'h77}, 16);
    repeat (10) @(posedge clk_in);
    #1.5 pdn_n = 1'b1;
    drain("power down");
    chk("timing bit", 8'h01, {7'h00, tr_bit});
    final_report();
  end
endmodule : dac_control_port_tb_top
`default_nettype wire
